/* File: verilog/ocfr_top.sv */
// Over-current fault response: limit compare, response sequencing, retries
//
// Function
// - Retry codes five, six: restart then latch off
// - Retry code seven restarts until off or fault
// - Delay count is two to field power
// - Unit length comes from separate time-unit setting
// - Delay times limiting or spaces restart attempts
// - Sixteen-bit linear limit sets the current threshold
// - Every fault sets status and alerts host
// - Response zero clamps current forever
// - Response one clamps unless voltage drops low
// - Response two clamps for delay, then retries
// - Response three disables until fault disappears
// - Retry zero never restarts; stays off
// - Restarts spaced by delay count times unit
// - Retry codes one to four restart then latch
`timescale 1ns/1ps
module ocfr_top
  import ocfr_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WE,
  output logic [15:0] REG_RDATA,
  input wire logic [15:0] IOUT,
  input wire logic VOUT_BELOW_LV,
  input wire logic [15:0] DELAY_UNIT_CYCLES,
  input wire logic OUTPUT_ON_CMD,
  input wire logic OTHER_FAULT_OFF,
  input wire logic FAULT_CLEAR,
  output logic OUTPUT_ENABLE,
  output logic CURRENT_LIMIT_EN,
  output logic [15:0] CURRENT_LIMIT_VALUE,
  output logic OC_FAULT_STATUS,
  output logic HOST_ALERT
);

  ////////////////////////////////////////////////////////////////////////////
  // Linear format to signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] ocfr_linear(input logic [15:0] word);
    logic signed [47:0] mant;
    logic signed [5:0] shift;
    mant = 48'(signed'(word[OCFR_EXP_LSB-1:0]));
    shift = 6'(signed'(word[15:OCFR_EXP_LSB])) + 6'(OCFR_FRAC_BITS);
    ocfr_linear = mant <<< shift[4:0];
  endfunction : ocfr_linear

  // Number of delay units for a three-bit field
  function automatic logic [7:0] ocfr_units(input logic [2:0] field);
    ocfr_units = 8'h01 << field;
  endfunction : ocfr_units

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] limit_reg;
  logic [7:0] response_reg;
  logic [15:0] rdata_reg;

  // Writes to other command codes are dropped silently
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      limit_reg <= OCFR_LIMIT_RESET;
      response_reg <= OCFR_RESPONSE_RESET;
    end
    else if (REG_WE)
    begin
      if (REG_ADDR == OCFR_ADDR_LIMIT)
        limit_reg <= REG_WDATA;
      if (REG_ADDR == OCFR_ADDR_RESPONSE)
        response_reg <= REG_WDATA[7:0];
    end
  end

  // Read data registered one cycle after the address; unmapped reads zero
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      rdata_reg <= 16'h0000;
    else if (REG_ADDR == OCFR_ADDR_LIMIT)
      rdata_reg <= limit_reg;
    else if (REG_ADDR == OCFR_ADDR_RESPONSE)
      rdata_reg <= {8'h00, response_reg};
    else
      rdata_reg <= 16'h0000;
  end

  assign REG_RDATA = rdata_reg;

  logic [1:0] resp_mode;
  logic [2:0] retry_field;
  logic [2:0] delay_field;

  assign resp_mode = response_reg[OCFR_RESP_MSB:OCFR_RESP_LSB];
  assign retry_field = response_reg[OCFR_RETRY_MSB:OCFR_RETRY_LSB];
  assign delay_field = response_reg[OCFR_DELAY_MSB:OCFR_DELAY_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Over-current compare
  logic oc_fault;
  logic oc_fault_d_reg;
  logic oc_rise;
  logic off_cmd;

  assign oc_fault = ocfr_linear(IOUT) > ocfr_linear(limit_reg);
  // Other shutdowns act like a command off
  assign off_cmd = !OUTPUT_ON_CMD || OTHER_FAULT_OFF;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      oc_fault_d_reg <= 1'b0;
    else
      oc_fault_d_reg <= oc_fault;
  end

  // Edge only: a clear during a standing fault stays cleared
  assign oc_rise = oc_fault && !oc_fault_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Delay timer
  ocfr_timer_if tmr ();

  ocfr_timer u_timer (
    .clk(CLK),
    .reset_n(RESET_N),
    .tmr(tmr)
  );

  logic tmr_start;

  assign tmr.units = ocfr_units(delay_field);
  // A zero unit length behaves as one cycle in the timer
  assign tmr.unit_cycles = DELAY_UNIT_CYCLES;
  assign tmr.start = tmr_start;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  ocfr_state_t state_reg;
  ocfr_state_t state_next;
  logic [2:0] retries_reg;
  logic retry_take;
  logic shutdown;
  logic can_retry;

  // Continuous retry never consumes the counter
  assign can_retry = (retry_field == OCFR_RETRY_CONT) || (retries_reg != OCFR_RETRY_NONE);

  always_comb
  begin
    state_next = state_reg;
    tmr_start = 1'b0;
    retry_take = 1'b0;
    shutdown = 1'b0;
    case (state_reg)
      OCFR_RUN:
      begin
        if (!off_cmd && oc_fault)
        begin
          if (resp_mode == OCFR_RESP_RESUME)
            state_next = OCFR_RESUME_WAIT;
          else
          begin
            state_next = OCFR_LIMIT;
            tmr_start = (resp_mode == OCFR_RESP_DELAY_RETRY);
          end
        end
      end
      OCFR_LIMIT:
      begin
        if (!oc_fault)
          state_next = OCFR_RUN;
        else if (resp_mode == OCFR_RESP_LIMIT_LV && VOUT_BELOW_LV)
          shutdown = 1'b1;
        else if (resp_mode == OCFR_RESP_DELAY_RETRY && tmr.expired)
          shutdown = 1'b1;
        else if (resp_mode == OCFR_RESP_RESUME)
          state_next = OCFR_RESUME_WAIT;
        // Mode switched to timed limiting while already clamping
        else if (resp_mode == OCFR_RESP_DELAY_RETRY && !tmr.busy)
          tmr_start = 1'b1;
      end
      OCFR_RETRY_WAIT:
      begin
        if (tmr.expired)
          state_next = OCFR_RUN;
      end
      OCFR_LATCHED:
      begin
        if (FAULT_CLEAR)
          state_next = OCFR_RUN;
      end
      OCFR_RESUME_WAIT:
      begin
        if (!oc_fault)
          state_next = OCFR_RUN;
      end
      default:
        state_next = OCFR_RUN;
    endcase
    if (shutdown)
    begin
      if (can_retry)
      begin
        // Restart spacing runs from the shutdown to the restart
        state_next = OCFR_RETRY_WAIT;
        tmr_start = 1'b1;
        retry_take = 1'b1;
      end
      else
        state_next = OCFR_LATCHED;
    end
    if (off_cmd)
    begin
      state_next = OCFR_RUN;
      tmr_start = 1'b0;
      retry_take = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      state_reg <= OCFR_RUN;
    else
      state_reg <= state_next;
  end

  // Remaining restart attempts
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      retries_reg <= OCFR_RETRY_NONE;
    else if (off_cmd || FAULT_CLEAR)
      retries_reg <= retry_field;
    // A new response setting starts a fresh retry budget
    else if (REG_WE && REG_ADDR == OCFR_ADDR_RESPONSE)
      retries_reg <= REG_WDATA[OCFR_RETRY_MSB:OCFR_RETRY_LSB];
    else if (retry_take && retry_field != OCFR_RETRY_CONT)
      retries_reg <= retries_reg - 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and host notification; a new fault wins over a clear
  logic status_reg;
  logic alert_reg;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      status_reg <= 1'b0;
    else if (oc_rise)
      status_reg <= 1'b1;
    else if (FAULT_CLEAR)
      status_reg <= 1'b0;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      alert_reg <= 1'b0;
    else if (oc_rise)
      alert_reg <= 1'b1;
    else if (FAULT_CLEAR)
      alert_reg <= 1'b0;
  end

  assign OC_FAULT_STATUS = status_reg;
  assign HOST_ALERT = alert_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Power stage controls, registered
  logic out_en_reg;
  logic limit_en_reg;

  // Registered so the power stage never sees a decode glitch
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      out_en_reg <= 1'b0;
    else
      out_en_reg <= !off_cmd && (state_next == OCFR_RUN || state_next == OCFR_LIMIT);
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      limit_en_reg <= 1'b0;
    else
      limit_en_reg <= !off_cmd && state_next == OCFR_LIMIT;
  end

  assign OUTPUT_ENABLE = out_en_reg;
  assign CURRENT_LIMIT_EN = limit_en_reg;
  assign CURRENT_LIMIT_VALUE = limit_reg;

endmodule : ocfr_top

/* File: verilog/ocfr_pkg.sv */
// Package of constants and types for the over-current fault response block
package ocfr_pkg;

  // Command codes of the two registers
  localparam logic [7:0] OCFR_ADDR_LIMIT = 8'h46;
  localparam logic [7:0] OCFR_ADDR_RESPONSE = 8'h47;

  // Values after reset
  localparam logic [15:0] OCFR_LIMIT_RESET = 16'h03ff; // Top mantissa bit is the sign
  localparam logic [7:0] OCFR_RESPONSE_RESET = 8'h00;

  // Field positions in the response register
  localparam int OCFR_RESP_MSB = 7;
  localparam int OCFR_RESP_LSB = 6;
  localparam int OCFR_RETRY_MSB = 5;
  localparam int OCFR_RETRY_LSB = 3;
  localparam int OCFR_DELAY_MSB = 2;
  localparam int OCFR_DELAY_LSB = 0;

  // Response codes
  localparam logic [1:0] OCFR_RESP_LIMIT = 2'h0;
  localparam logic [1:0] OCFR_RESP_LIMIT_LV = 2'h1;
  localparam logic [1:0] OCFR_RESP_DELAY_RETRY = 2'h2;
  localparam logic [1:0] OCFR_RESP_RESUME = 2'h3;

  // Retry codes
  localparam logic [2:0] OCFR_RETRY_NONE = 3'h0;
  localparam logic [2:0] OCFR_RETRY_CONT = 3'h7;

  // Linear format layout: 5-bit exponent over an 11-bit mantissa
  localparam int OCFR_EXP_LSB = 11;
  localparam int OCFR_FRAC_BITS = 16;

  typedef enum logic [2:0] {
    OCFR_RUN,
    OCFR_LIMIT,
    OCFR_RETRY_WAIT,
    OCFR_LATCHED,
    OCFR_RESUME_WAIT
  } ocfr_state_t;

endpackage : ocfr_pkg

/* File: verilog/ocfr_timer_if.sv */
// Interface between the fault sequencer and its delay timer
`timescale 1ns/1ps
interface ocfr_timer_if;
  logic start;
  logic [7:0] units;
  logic [15:0] unit_cycles;
  logic busy;
  logic expired;

  modport ctrl (output start, output units, output unit_cycles, input busy, input expired);
  modport timer (input start, input units, input unit_cycles, output busy, output expired);
endinterface : ocfr_timer_if

/* File: verilog/ocfr_timer.sv */
// Delay timer counting whole delay units of a programmable length
`timescale 1ns/1ps
module ocfr_timer
  import ocfr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  ocfr_timer_if.timer tmr
);

  logic [15:0] prescale_reg;
  logic [7:0] units_reg;
  logic busy_reg;
  logic expired_reg;
  logic unit_tick;

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle enable at the end of each delay unit
  assign unit_tick = busy_reg && (prescale_reg <= 16'h0001);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prescale_reg <= 16'h0000;
    else if (tmr.start || unit_tick)
      prescale_reg <= tmr.unit_cycles;
    else if (busy_reg)
      prescale_reg <= prescale_reg - 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unit count and completion
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      units_reg <= 8'h00;
      busy_reg <= 1'b0;
      expired_reg <= 1'b0;
    end
    else if (tmr.start)
    begin
      units_reg <= tmr.units;
      busy_reg <= 1'b1;
      expired_reg <= 1'b0;
    end
    else if (unit_tick)
    begin
      units_reg <= units_reg - 8'h01;
      if (units_reg <= 8'h01)
      begin
        busy_reg <= 1'b0;
        expired_reg <= 1'b1;
      end
    end
    else
      expired_reg <= 1'b0;
  end

  assign tmr.busy = busy_reg;
  assign tmr.expired = expired_reg;

endmodule : ocfr_timer

/* File: tb/ocfr_chk.sv */
// Assertion checker for the over-current fault response top
`timescale 1ns/1ps
module ocfr_chk
  import ocfr_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WE,
  input wire logic [15:0] REG_RDATA,
  input wire logic [15:0] DELAY_UNIT_CYCLES,
  input wire logic VOUT_BELOW_LV,
  input wire logic OUTPUT_ON_CMD,
  input wire logic OTHER_FAULT_OFF,
  input wire logic FAULT_CLEAR,
  input wire logic OUTPUT_ENABLE,
  input wire logic CURRENT_LIMIT_EN,
  input wire logic [15:0] CURRENT_LIMIT_VALUE,
  input wire logic OC_FAULT_STATUS,
  input wire logic HOST_ALERT
);
  logic [1:0] resp_reg;
  logic on_ok;
  assign on_ok = OUTPUT_ON_CMD && !OTHER_FAULT_OFF;
  // Shadow of the response field taken from bus writes, the checker cannot read the register
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
      resp_reg <= 2'h0;
    else if (REG_WE && REG_ADDR == OCFR_ADDR_RESPONSE)
      resp_reg <= REG_WDATA[7:6];
  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_off_held;
    (!OUTPUT_ON_CMD || OTHER_FAULT_OFF)[*2];
  endsequence
  sequence s_gap;
    !OUTPUT_ENABLE[*2];
  endsequence
  property p_lim_wr;
    REG_WE && REG_ADDR == OCFR_ADDR_LIMIT |=> CURRENT_LIMIT_VALUE == $past(REG_WDATA);
  endproperty
  property p_lim_rd;
    !REG_WE && REG_ADDR == OCFR_ADDR_LIMIT |=> REG_RDATA == CURRENT_LIMIT_VALUE;
  endproperty
  property p_sticky;
    OC_FAULT_STATUS && !FAULT_CLEAR |=> OC_FAULT_STATUS;
  endproperty
  property p_alert;
    HOST_ALERT == OC_FAULT_STATUS;
  endproperty
  property p_flag;
    $rose(CURRENT_LIMIT_EN) |-> OC_FAULT_STATUS;
  endproperty
  property p_off;
    s_off_held |-> !OUTPUT_ENABLE && !CURRENT_LIMIT_EN;
  endproperty
  property p_clamp;
    CURRENT_LIMIT_EN |-> OUTPUT_ENABLE;
  endproperty
  property p_lv;
    resp_reg == OCFR_RESP_LIMIT_LV && CURRENT_LIMIT_EN && VOUT_BELOW_LV && on_ok
      |=> !OUTPUT_ENABLE;
  endproperty
  property p_space;
    $fell(OUTPUT_ENABLE) && on_ok && resp_reg == OCFR_RESP_DELAY_RETRY
      && DELAY_UNIT_CYCLES > 16'h0001 |-> s_gap;
  endproperty
  a_lim_wr: assert property (p_lim_wr) else $error("limit not taken");
  a_lim_rd: assert property (p_lim_rd) else $error("limit readback");
  a_sticky: assert property (p_sticky) else $error("status lost");
  a_alert: assert property (p_alert) else $error("alert differs");
  a_flag: assert property (p_flag) else $error("clamp without status");
  a_off: assert property (p_off) else $error("output on while off");
  a_clamp: assert property (p_clamp) else $error("clamp with output off");
  a_lv: assert property (p_lv) else $error("no low voltage shutdown");
  a_space: assert property (p_space) else $error("restart too soon");
endmodule : ocfr_chk

bind ocfr_top ocfr_chk i_ocfr_chk (.CLK(CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RDATA(REG_RDATA),
  .DELAY_UNIT_CYCLES(DELAY_UNIT_CYCLES), .VOUT_BELOW_LV(VOUT_BELOW_LV),
  .OUTPUT_ON_CMD(OUTPUT_ON_CMD), .OTHER_FAULT_OFF(OTHER_FAULT_OFF),
  .FAULT_CLEAR(FAULT_CLEAR), .OUTPUT_ENABLE(OUTPUT_ENABLE),
  .CURRENT_LIMIT_EN(CURRENT_LIMIT_EN), .CURRENT_LIMIT_VALUE(CURRENT_LIMIT_VALUE),
  .OC_FAULT_STATUS(OC_FAULT_STATUS), .HOST_ALERT(HOST_ALERT));

/* File: tb/ocfr_host.sv */
// Host model driving the register command bus
`timescale 1ns/1ps
module ocfr_host (
  input wire logic clk,
  input wire logic [15:0] rdata,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  output logic we
);
  initial
  begin
    addr = 8'h00;
    wdata = 16'h0000;
    we = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    // Stale data is inverted so a late capture shows up
    wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(negedge clk);
    d = rdata;
  endtask : rd
endmodule : ocfr_host

/* File: tb/ocfr_top_tb.sv */
// Self-checking bench for the over-current fault response block
`timescale 1ns/1ps
module ocfr_top_tb;
  import ocfr_pkg::*;
  localparam logic [15:0] lim_val = 16'h0064;
  localparam logic [15:0] i_hi = 16'h00c8;
  localparam logic [15:0] i_lo = 16'h0010;
  localparam int unit_cyc = 2;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, iout, clv, v;
  logic we, vlow, on_cmd, oth_off, fclr, oe, cle, sts, alert;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  int rises, lim, gap, u;
  always #20 clk = ~clk;
  ocfr_host i_ocfr_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .we(we));
  ocfr_top i_ocfr_top (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WE(we), .REG_RDATA(rdata), .IOUT(iout), .VOUT_BELOW_LV(vlow),
    .DELAY_UNIT_CYCLES(16'(unit_cyc)), .OUTPUT_ON_CMD(on_cmd), .OTHER_FAULT_OFF(oth_off),
    .FAULT_CLEAR(fclr), .OUTPUT_ENABLE(oe), .CURRENT_LIMIT_EN(cle),
    .CURRENT_LIMIT_VALUE(clv), .OC_FAULT_STATUS(sts), .HOST_ALERT(alert));
  ////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cycles
  // Clears the previous fault, then holds over-current for n cycles
  task automatic run(input logic [7:0] resp, input int n);
    logic prev;
    i_ocfr_host.wr(OCFR_ADDR_RESPONSE, {8'h00, resp});
    iout <= i_lo;
    fclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    repeat (3) @(posedge clk);
    iout <= i_hi;
    rises = 0;
    lim = 0;
    gap = 0;
    prev = 1'b1;
    repeat (n)
    begin
      @(negedge clk);
      if (oe && !prev)
        rises++;
      if (cle)
        lim++;
      if (!oe && rises == 0)
        gap++;
      prev = oe;
    end
  endtask : run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    iout = 16'h0000;
    vlow = 1'b0;
    on_cmd = 1'b1;
    oth_off = 1'b0;
    fclr = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    i_ocfr_host.rd(OCFR_ADDR_LIMIT, v);
    check("limit reset", v, OCFR_LIMIT_RESET);
    i_ocfr_host.wr(8'h50, 16'h1234);
    i_ocfr_host.rd(8'h50, v);
    check("unmapped", v, 16'h0000);
    i_ocfr_host.wr(OCFR_ADDR_LIMIT, lim_val);
    i_ocfr_host.rd(OCFR_ADDR_LIMIT, v);
    check("limit", v, lim_val);
    run(8'h00, 20);
    check("clamp", {oe, cle, sts, alert}, 4'hf);
    check("clamp value", clv, lim_val);
    run(8'hc0, 20);
    check("resume off", oe, 1'b0);
    @(posedge clk) iout <= i_lo;
    cycles(3);
    check("resume on", oe, 1'b1);
    run(8'h40, 10);
    check("lv clamp", cle, 1'b1);
    @(posedge clk) vlow <= 1'b1;
    cycles(3);
    check("lv shut", oe, 1'b0);
    @(posedge clk) vlow <= 1'b0;
    cycles(5);
    check("no retry", oe, 1'b0);
    for (int n = 0; n < 7; n++)
    begin
      run(8'h80 | 8'(n << 3), 150);
      check("restarts", 16'(rises), 16'(n));
      check("latched", oe, 1'b0);
    end
    run(8'hb8, 150);
    check("continuous", rises > 6, 1'b1);
    @(posedge clk) oth_off <= 1'b1;
    cycles(3);
    check("forced off", {oe, cle}, 2'b00);
    @(posedge clk) oth_off <= 1'b0;
    for (int d = 3; d < 8; d += 4)
    begin
      u = (1 << d) * unit_cyc;
      run(8'h80 | 8'(d), 300);
      check("delay", lim >= u && lim <= u + 3, 1'b1);
    end
    run(8'h8a, 100);
    u = 4 * unit_cyc;
    check("spacing", gap >= u && gap <= u + 3, 1'b1);
    @(posedge clk) on_cmd <= 1'b0;
    cycles(2);
    @(posedge clk) on_cmd <= 1'b1;
    cycles(2);
    check("fresh retries", oe, 1'b1);
    // Off reloaded one attempt: exactly one restart, then latched
    rises = 0;
    u = 0;
    repeat (40)
    begin
      @(negedge clk);
      if (oe && u == 1)
        rises++;
      u = !oe;
    end
    check("fresh restart", 16'(rises), 16'h0001);
    check("fresh latched", oe, 1'b0);
    close_out();
  end
endmodule : ocfr_top_tb
